// >>> shared/imd_pkg.sv
// shared constants and carrier types for the indirect management register portal
package imd_pkg;
  // =========================================
  // widths
  localparam int DEV_W = 5;
  localparam int DATA_W = 16;
  // =========================================
  // implemented locations
  localparam logic [4:0] DEV_LED = 5'h02;
  localparam logic [15:0] REG_LED = 16'h0000;
  localparam logic [4:0] DEV_EEE = 5'h07;
  localparam logic [15:0] REG_EEE = 16'h003c;
  // =========================================
  // field positions
  localparam int FN_MSB = 15;
  localparam int FN_LSB = 14;
  localparam int LED_MODE_BIT = 4;
  localparam int EEE_1000_BIT = 2;
  localparam int EEE_100_BIT = 1;
  // =========================================
  // reset values, the fixed led low nibble and the address step
  localparam logic LED_MODE_RST = 1'b0;
  localparam logic EEE_1000_RST = 1'b1;
  localparam logic EEE_100_RST = 1'b1;
  localparam logic [3:0] LED_LOW_RO = 4'h1;
  localparam logic [4:0] DEV_RST = 5'h00;
  localparam logic [15:0] ADDR_RST = 16'h0000;
  localparam logic [15:0] DATA_ZERO = 16'h0000;
  localparam logic [15:0] ADDR_STEP = 16'h0001;

  // setup portal function field
  typedef enum logic [1:0] {
    IMD_FN_ADDR,
    IMD_FN_DATA,
    IMD_FN_INC_RW,
    IMD_FN_INC_WR
  } imd_func_t;

  // one portal access per cycle
  typedef struct packed {
    logic wr;
    logic rd;
    logic sel_data;
    logic [15:0] wdata;
  } imd_req_t;

  // settings that steer the port
  typedef struct packed {
    logic led_single;
    logic eee_1000;
    logic eee_100;
  } imd_cfg_t;
endpackage

// >>> hw/imd_portal.sv
// indirect management register portal with led mode and eee advertisement registers
`timescale 1ns/1ps

// How it works
// - setup portal device field names any of 32 device addresses
// - each device has a 16-bit register address, 16-bit wide locations
// - only device 2 register 00h and device 7 register 3Ch exist
// - all traffic goes through the setup portal and the data portal
// - in address function a data portal write loads the register address
// - function data without increment makes data accesses reach contents
// - in data function a data portal write stores into the selected register
// - read/write increment advances the register address after each data access; write increment only after data writes
// - in data function a data portal read returns the selected contents
// - led mode register sits at device 02h register 00h, 16 bits
// - led bit 4 writable, resets 0, 1 means single led; 15:5 zero
// - eee advertisement register sits at device 07h register 3Ch, 16 bits
// - eee bit 2 writable, resets 1, advertises 1000 Mbps capability
// - eee bit 1 writable, resets 1, 100 Mbps; other bits read zero
module imd_portal (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire imd_pkg::imd_req_t req,
  output logic [15:0] rd_data,
  output logic rd_valid,
  output imd_pkg::imd_cfg_t cfg
);

  // =========================================
  // helpers
  function automatic logic hit_led(input logic [4:0] dev, input logic [15:0] addr);
    hit_led = (dev == imd_pkg::DEV_LED) && (addr == imd_pkg::REG_LED);
  endfunction

  function automatic logic hit_eee(input logic [4:0] dev, input logic [15:0] addr);
    hit_eee = (dev == imd_pkg::DEV_EEE) && (addr == imd_pkg::REG_EEE);
  endfunction

  // wraps at the top of the space, so a burst past the last location restarts at zero
  function automatic logic [15:0] step_addr(input logic [15:0] addr);
    step_addr = 16'(addr + imd_pkg::ADDR_STEP);
  endfunction

  // =========================================
  // state
  imd_pkg::imd_func_t func_r, func_nxt;
  logic [4:0] dev_r, dev_nxt;
  logic [15:0] addr_r, addr_nxt;
  logic led_r, led_nxt;
  logic eee1000_r, eee1000_nxt;
  logic eee100_r, eee100_nxt;
  logic [15:0] rd_data_r, rd_data_nxt;
  logic rd_valid_r, rd_valid_nxt;
  logic data_acc;
  logic led_hit;
  logic eee_hit;
  logic [15:0] led_word;
  logic [15:0] eee_word;
  logic [15:0] setup_word;

  // register images as software sees them
  always_comb begin
    led_word = {11'h000, led_r, imd_pkg::LED_LOW_RO};
    eee_word = {13'h0000, eee1000_r, eee100_r, 1'b0};
    setup_word = {func_r, 9'h000, dev_r};
    led_hit = hit_led(dev_r, addr_r);
    eee_hit = hit_eee(dev_r, addr_r);
    data_acc = req.sel_data && (func_r != imd_pkg::IMD_FN_ADDR);
  end

  // portal decode: a write wins over a read issued in the same cycle
  always_comb begin
    func_nxt = func_r;
    dev_nxt = dev_r;
    addr_nxt = addr_r;
    led_nxt = led_r;
    eee1000_nxt = eee1000_r;
    eee100_nxt = eee100_r;
    rd_data_nxt = rd_data_r;
    rd_valid_nxt = 1'b0;
    if (req.wr && !req.sel_data) begin
      // setup portal: function and device, middle bits ignored
      func_nxt = imd_pkg::imd_func_t'(req.wdata[imd_pkg::FN_MSB:imd_pkg::FN_LSB]);
      dev_nxt = req.wdata[imd_pkg::DEV_W-1:0];
    end else if (req.wr && !data_acc) begin
      addr_nxt = req.wdata;
    end else if (req.wr) begin
      // only the writable bits take; reserved bits and empty locations drop it
      if (led_hit) begin
        led_nxt = req.wdata[imd_pkg::LED_MODE_BIT];
      end else if (eee_hit) begin
        eee1000_nxt = req.wdata[imd_pkg::EEE_1000_BIT];
        eee100_nxt = req.wdata[imd_pkg::EEE_100_BIT];
      end
      if (func_r == imd_pkg::IMD_FN_INC_RW || func_r == imd_pkg::IMD_FN_INC_WR) begin
        addr_nxt = step_addr(addr_r);
      end
    end else if (req.rd) begin
      rd_valid_nxt = 1'b1;
      if (!req.sel_data) begin
        rd_data_nxt = setup_word;
      end else if (!data_acc) begin
        rd_data_nxt = addr_r;
      end else begin
        if (led_hit) begin
          rd_data_nxt = led_word;
        end else if (eee_hit) begin
          rd_data_nxt = eee_word;
        end else begin
          rd_data_nxt = imd_pkg::DATA_ZERO;
        end
        // increment on reads only in the read/write auto-increment mode
        if (func_r == imd_pkg::IMD_FN_INC_RW) begin
          addr_nxt = step_addr(addr_r);
        end
      end
    end
  end

  // registers; clock enable low freezes everything
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      func_r <= imd_pkg::IMD_FN_ADDR;
      dev_r <= imd_pkg::DEV_RST;
      addr_r <= imd_pkg::ADDR_RST;
      led_r <= imd_pkg::LED_MODE_RST;
      eee1000_r <= imd_pkg::EEE_1000_RST;
      eee100_r <= imd_pkg::EEE_100_RST;
      rd_data_r <= imd_pkg::DATA_ZERO;
      rd_valid_r <= 1'b0;
    end else if (clk_en) begin
      func_r <= func_nxt;
      dev_r <= dev_nxt;
      addr_r <= addr_nxt;
      led_r <= led_nxt;
      eee1000_r <= eee1000_nxt;
      eee100_r <= eee100_nxt;
      rd_data_r <= rd_data_nxt;
      rd_valid_r <= rd_valid_nxt;
    end
  end

  // outputs straight from flops
  assign rd_data = rd_data_r;
  assign rd_valid = rd_valid_r;
  assign cfg = '{led_single: led_r, eee_1000: eee1000_r, eee_100: eee100_r};

  // =========================================
  // checks
  // every property samples on the rising clock edge and is muted while reset is high;
  // a cycle with the clock enable low takes nothing, so each access trigger carries it
  sequence s_data_wr;
    clk_en && req.wr && data_acc;
  endsequence

  sequence s_data_rd;
    clk_en && !req.wr && req.rd && data_acc;
  endsequence

  // either kind of contents access, for the address stepping checks
  sequence s_data_any;
    clk_en && (req.wr || req.rd) && data_acc;
  endsequence

  // setup portal write taken
  sequence s_setup_wr;
    clk_en && req.wr && !req.sel_data;
  endsequence

  // setup portal read taken
  sequence s_setup_rd;
    clk_en && !req.wr && req.rd && !req.sel_data;
  endsequence

  // data portal read while the address function is selected
  sequence s_addr_rd;
    clk_en && !req.wr && req.rd && req.sel_data && !data_acc;
  endsequence

  // no read taken: a write beside it wins, or there is no read strobe
  sequence s_no_rd;
    clk_en && (req.wr || !req.rd);
  endsequence

  // device and function land together on a setup write
  a_setup_dev_load: assert property (@(posedge ref_clk) disable iff (sys_rst)
    s_setup_wr |=> dev_r == $past(req.wdata[imd_pkg::DEV_W-1:0])
      && func_r == $past(req.wdata[imd_pkg::FN_MSB:imd_pkg::FN_LSB]))
    else $error("setup portal write not captured");

  // a setup write moves neither the register address nor the settings
  a_setup_keeps_addr: assert property (@(posedge ref_clk) disable iff (sys_rst)
    s_setup_wr |=> $stable(addr_r) && $stable(cfg))
    else $error("setup write disturbed address or settings");

  // setup read shows function and device, middle bits zero
  a_setup_read: assert property (@(posedge ref_clk) disable iff (sys_rst)
    s_setup_rd |=> rd_valid && rd_data == {$past(func_r), 9'h000, $past(dev_r)})
    else $error("setup portal read wrong");

  // address function: data write loads the register address
  a_addr_load: assert property (@(posedge ref_clk) disable iff (sys_rst)
    clk_en && req.wr && req.sel_data && func_r == imd_pkg::IMD_FN_ADDR |=> addr_r == $past(req.wdata))
    else $error("register address not loaded");

  // loading an address must not touch register contents
  a_addr_wr_keeps_cfg: assert property (@(posedge ref_clk) disable iff (sys_rst)
    clk_en && req.wr && req.sel_data && func_r == imd_pkg::IMD_FN_ADDR |=> $stable(cfg))
    else $error("address load changed a register");

  // address function: data read returns the register address
  a_addr_read: assert property (@(posedge ref_clk) disable iff (sys_rst)
    s_addr_rd |=> rd_valid && rd_data == $past(addr_r))
    else $error("register address read wrong");

  // led mode bit takes the written value
  a_led_write: assert property (@(posedge ref_clk) disable iff (sys_rst)
    s_data_wr ##0 led_hit |=> cfg.led_single == $past(req.wdata[imd_pkg::LED_MODE_BIT]))
    else $error("led mode write lost");

  // a led write leaves the advertisement alone
  a_led_write_alone: assert property (@(posedge ref_clk) disable iff (sys_rst)
    s_data_wr ##0 led_hit |=> $stable(cfg.eee_1000) && $stable(cfg.eee_100))
    else $error("led write leaked into advertisement");

  // both advertisement bits take the written value
  a_eee_write: assert property (@(posedge ref_clk) disable iff (sys_rst)
    s_data_wr ##0 eee_hit |=> cfg.eee_1000 == $past(req.wdata[imd_pkg::EEE_1000_BIT])
      && cfg.eee_100 == $past(req.wdata[imd_pkg::EEE_100_BIT]))
    else $error("eee advertisement write lost");

  // an advertisement write leaves the led mode alone
  a_eee_write_alone: assert property (@(posedge ref_clk) disable iff (sys_rst)
    s_data_wr ##0 eee_hit |=> $stable(cfg.led_single))
    else $error("advertisement write leaked into led mode");

  // writes to empty locations leave the settings alone
  a_empty_write: assert property (@(posedge ref_clk) disable iff (sys_rst)
    s_data_wr ##0 (!led_hit && !eee_hit) |=> $stable(cfg))
    else $error("unimplemented location write took effect");

  // led register image with its fixed low nibble
  a_led_read: assert property (@(posedge ref_clk) disable iff (sys_rst)
    s_data_rd ##0 led_hit |=> rd_valid && rd_data == {11'h000, cfg.led_single, imd_pkg::LED_LOW_RO})
    else $error("led mode read wrong");

  // advertisement image, reserved bits zero
  a_eee_read: assert property (@(posedge ref_clk) disable iff (sys_rst)
    s_data_rd ##0 eee_hit |=> rd_valid && rd_data == {13'h0000, cfg.eee_1000, cfg.eee_100, 1'b0})
    else $error("eee advertisement read wrong");

  // empty locations read zero
  a_empty_read: assert property (@(posedge ref_clk) disable iff (sys_rst)
    s_data_rd ##0 (!led_hit && !eee_hit) |=> rd_valid && rd_data == imd_pkg::DATA_ZERO)
    else $error("unimplemented location not zero");

  // the answer flag is a one-cycle pulse tied to a taken read
  a_read_dropped: assert property (@(posedge ref_clk) disable iff (sys_rst)
    s_no_rd |=> !rd_valid)
    else $error("answer flagged without a read");

  // the last answer stays put until the next read
  a_rd_data_hold: assert property (@(posedge ref_clk) disable iff (sys_rst)
    s_no_rd |=> $stable(rd_data))
    else $error("answer changed without a read");

  // reads and idle cycles never change settings or the setup
  a_read_keeps_state: assert property (@(posedge ref_clk) disable iff (sys_rst)
    clk_en && !req.wr |=> $stable(cfg) && $stable(func_r) && $stable(dev_r))
    else $error("state changed without a write");

  // read/write increment: every contents access steps the address
  a_inc_step: assert property (@(posedge ref_clk) disable iff (sys_rst)
    s_data_any ##0 func_r == imd_pkg::IMD_FN_INC_RW |=> addr_r == 16'($past(addr_r) + imd_pkg::ADDR_STEP))
    else $error("auto increment missed");

  // write-only increment: a contents write steps the address
  a_inc_wr_step: assert property (@(posedge ref_clk) disable iff (sys_rst)
    s_data_wr ##0 func_r == imd_pkg::IMD_FN_INC_WR |=> addr_r == 16'($past(addr_r) + imd_pkg::ADDR_STEP))
    else $error("write increment missed");

  // write-only increment: a contents read leaves the address
  a_inc_wr_read_hold: assert property (@(posedge ref_clk) disable iff (sys_rst)
    s_data_rd ##0 func_r == imd_pkg::IMD_FN_INC_WR |=> $stable(addr_r))
    else $error("read stepped the address in write increment");

  // plain data function never steps the address
  a_no_inc: assert property (@(posedge ref_clk) disable iff (sys_rst)
    s_data_any ##0 func_r == imd_pkg::IMD_FN_DATA |=> $stable(addr_r))
    else $error("address moved without increment");

  // clock enable low freezes address, settings and answer flag
  a_freeze_hold: assert property (@(posedge ref_clk) disable iff (sys_rst)
    !clk_en |=> $stable(addr_r) && $stable(cfg) && $stable(rd_valid))
    else $error("state changed while frozen");

  // clock enable low freezes the setup and the answer too
  a_freeze_setup: assert property (@(posedge ref_clk) disable iff (sys_rst)
    !clk_en |=> $stable(func_r) && $stable(dev_r) && $stable(rd_data))
    else $error("setup or answer changed while frozen");

  // the first edge after reset sees every register at its reset value
  a_reset_state: assert property (@(posedge ref_clk) disable iff (sys_rst)
    $fell(sys_rst) |-> cfg == {imd_pkg::LED_MODE_RST, imd_pkg::EEE_1000_RST, imd_pkg::EEE_100_RST}
      && !rd_valid && rd_data == imd_pkg::DATA_ZERO && func_r == imd_pkg::IMD_FN_ADDR
      && dev_r == imd_pkg::DEV_RST && addr_r == imd_pkg::ADDR_RST)
    else $error("register not at its reset value after reset");

endmodule // imd_portal

// >>> tb/imd_portal_bench.sv
// self-checking bench for the indirect management register portal
`timescale 1ns/1ps
module imd_portal_bench;
  // =========================================
  // stimulus and observed signals
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic clk_en = 1'b1;
  imd_pkg::imd_req_t req = '0;
  logic [15:0] rd_data;
  logic rd_valid;
  imd_pkg::imd_cfg_t cfg;
  int failures = 0;
  int tests_run = 0;

  // 25 MHz clock
  always #20 ref_clk = ~ref_clk;

  imd_portal DUT (.ref_clk(ref_clk), .sys_rst(sys_rst), .clk_en(clk_en), .req(req), .rd_data(rd_data),
    .rd_valid(rd_valid), .cfg(cfg));

  // =========================================
  // access tasks
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // whole request set once, 1 ns after the edge; strobes stay up so back to back is legal
  task automatic acc(input logic w, input logic r, input logic sel, input logic [15:0] d);
    req = '{w, r, sel, d};
    @(posedge ref_clk);
    #1;
  endtask

  task automatic wr(input logic sel, input logic [15:0] d);
    acc(1'b1, 1'b0, sel, d);
  endtask

  // answer is registered, so it is settled one edge after the read is taken
  task automatic rd(input logic sel, input logic [15:0] exp);
    acc(1'b0, 1'b1, sel, 16'h0000);
    chk({15'h0000, rd_valid}, 16'h0001);
    chk(rd_data, exp);
  endtask

  task automatic sel_reg(input logic [4:0] dev, input logic [15:0] addr, input imd_pkg::imd_func_t fn);
    wr(1'b0, {imd_pkg::IMD_FN_ADDR, 9'h000, dev});
    wr(1'b1, addr);
    wr(1'b0, {fn, 9'h000, dev});
  endtask

  task automatic end_of_test();
    $display("comparisons %0d, mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // =========================================
  // watchdog, far beyond the roughly 50 cycles the tests need
  initial begin
    #200000;
    failures++;
    end_of_test();
  end

  // =========================================
  // test sequence
  initial begin
    repeat (6) @(posedge ref_clk);
    #1 sys_rst = 1'b0;
    chk({13'h0000, cfg}, 16'h0003);
    sel_reg(5'h02, 16'h0000, imd_pkg::IMD_FN_DATA);
    rd(1'b1, 16'h0001);
    sel_reg(5'h07, 16'h003c, imd_pkg::IMD_FN_INC_RW);
    rd(1'b1, 16'h0006);
    wr(1'b0, 16'h0007);
    rd(1'b1, 16'h003d);
    rd(1'b0, 16'h0007);
    $display("test reset_and_read done");
    sel_reg(5'h02, 16'h0000, imd_pkg::IMD_FN_DATA);
    wr(1'b1, 16'h0010);
    chk({15'h0000, cfg.led_single}, 16'h0001);
    rd(1'b1, 16'h0011);
    wr(1'b1, 16'hffef);
    rd(1'b1, 16'h0001);
    $display("test led_mode done");
    sel_reg(5'h07, 16'h003c, imd_pkg::IMD_FN_DATA);
    wr(1'b1, 16'h0000);
    chk({13'h0000, cfg}, 16'h0000);
    rd(1'b1, 16'h0000);
    wr(1'b1, 16'hffff);
    rd(1'b1, 16'h0006);
    $display("test eee_advert done");
    // top device and top address; increment wraps to zero
    sel_reg(5'h1f, 16'hffff, imd_pkg::IMD_FN_INC_RW);
    rd(1'b0, 16'h801f);
    wr(1'b1, 16'hffff);
    rd(1'b1, 16'h0000);
    wr(1'b0, 16'h001f);
    rd(1'b1, 16'h0001);
    chk({13'h0000, cfg}, 16'h0003);
    $display("test unimplemented done");
    // increment on writes only
    sel_reg(5'h02, 16'h0000, imd_pkg::IMD_FN_INC_WR);
    rd(1'b1, 16'h0001);
    rd(1'b1, 16'h0001);
    wr(1'b1, 16'h0010);
    chk({15'h0000, cfg.led_single}, 16'h0001);
    rd(1'b1, 16'h0000);
    $display("test write_increment done");
    // read beside a write is dropped; a disabled clock takes nothing
    acc(1'b1, 1'b1, 1'b0, 16'h4007);
    chk({15'h0000, rd_valid}, 16'h0000);
    chk(rd_data, 16'h0000);
    clk_en = 1'b0;
    wr(1'b0, 16'h0002);
    clk_en = 1'b1;
    rd(1'b0, 16'h4007);
    sys_rst = 1'b1;
    @(posedge ref_clk);
    #1 sys_rst = 1'b0;
    chk({13'h0000, cfg}, 16'h0003);
    chk({15'h0000, rd_valid}, 16'h0000);
    chk(rd_data, 16'h0000);
    rd(1'b0, 16'h0000);
    rd(1'b1, 16'h0000);
    $display("test refusals_and_reset done");
    end_of_test();
  end
endmodule // imd_portal_bench
